// ---- common/scc_pkg.sv ----
// Package of register map, field positions, reset values and timing for the sync, clamp and clock control
package scc_pkg;

  // Register offsets
  localparam logic [7:0] REG_PHASE      = 8'h04;
  localparam logic [7:0] REG_CLAMP_DLY  = 8'h05;
  localparam logic [7:0] REG_CLAMP_DUR  = 8'h06;
  localparam logic [7:0] REG_HSYNC_CTL  = 8'h0E;
  localparam logic [7:0] REG_MODE_CTL   = 8'h0F;
  localparam logic [7:0] REG_CLOCK_CTL  = 8'h15;
  localparam logic [7:0] REG_STATUS     = 8'h20;

  // Field positions
  localparam int HSYNC_POL_BIT   = 6;
  localparam int EXT_CLAMP_BIT   = 7;
  localparam int CLAMP_POL_BIT   = 6;
  localparam int COAST_POL_BIT   = 3;
  localparam int MIDSCALE_BIT    = 2;
  localparam int EXT_CLK_SEL_BIT = 0;
  localparam int PHASE_W         = 5;

  // Reset values
  localparam logic             HSYNC_POL_RST   = 1'h0;
  localparam logic             EXT_CLAMP_RST   = 1'h0;
  localparam logic             CLAMP_POL_RST   = 1'h1;
  localparam logic             COAST_POL_RST   = 1'h1;
  localparam logic             MIDSCALE_RST    = 1'h0;
  localparam logic             EXT_CLK_SEL_RST = 1'h0;
  localparam logic [PHASE_W-1:0] PHASE_RST     = 5'h00;
  localparam logic [7:0]       CLAMP_DLY_RST   = 8'h08;
  localparam logic [7:0]       CLAMP_DUR_RST   = 8'h14;

  // Timing: internal pixel clock half period in system clocks
  localparam logic [3:0] PIX_HALF_CYCLES = 4'h4;
  // Top input rate reachable by alternate pixel sampling, in MSPS
  localparam int ALT_SAMPLE_MAX_MSPS = 410;

endpackage : scc_pkg

// ---- rtl/scc_sync.sv ----
// Two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module scc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // First stage is read only by the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : scc_sync

// ---- rtl/scc_clamp_gen.sv ----
// Internal clamp interval generator: delay then duration after a start pulse
`timescale 1ns/100ps
module scc_clamp_gen
  import scc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       start,
  input  wire logic [7:0] delay,
  input  wire logic [7:0] duration,
  output logic            active
);

  typedef enum logic [1:0] {CG_IDLE, CG_DELAY, CG_HOLD} scc_cg_e;

  scc_cg_e    state;
  logic [7:0] cnt;

  // Start accepted only when idle, so a stray edge cannot stretch a clamp
  always_ff @(posedge clk) begin
    if (srst) begin
      state  <= CG_IDLE;
      cnt    <= 8'h00;
      active <= 1'b0;
    end else begin
      unique case (state)
        CG_IDLE: begin
          if (start) begin
            state <= CG_DELAY;
            cnt   <= delay;
          end
        end
        CG_DELAY: begin
          if (cnt == 8'h00) begin
            state  <= (duration == 8'h00) ? CG_IDLE : CG_HOLD;
            cnt    <= duration - 8'h01;
            active <= (duration != 8'h00);
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        CG_HOLD: begin
          if (cnt == 8'h00) begin
            state  <= CG_IDLE;
            active <= 1'b0;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
      endcase
    end
  end

  property p_clamp_not_at_start;
    @(posedge clk) disable iff (srst)
      (start && state == CG_IDLE) |=> !active;
  endproperty
  a_clamp_not_at_start: assert property (p_clamp_not_at_start) else $error("clamp active right after start");

endmodule : scc_clamp_gen

// ---- rtl/scc_top.sv ----
// Sync, clamp and pixel clock control of a triple-channel graphics digitizer
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module scc_top
  import scc_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               srst,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wr_data,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rd_data,
  input  wire logic               hsync_in,
  input  wire logic               clamp_in,
  input  wire logic               coast_in,
  input  wire logic               alt_pixel_clock_in,
  input  wire logic               sample_clock_invert,
  input  wire logic               green_embedded_sync_in,
  output logic                    clamp_active,
  output logic                    clamp_to_midscale,
  output logic                    pll_ref_edge,
  output logic                    pll_coast,
  output logic                    pixel_clock_ext_sel,
  output logic                    pixel_clock_out,
  output logic                    sample_clock_out,
  output logic                    sample_clock_inverted,
  output logic      [PHASE_W-1:0] phase_adjust,
  output logic                    composite_sync_out
);

  // Control registers
  logic               hsync_pol;
  logic               ext_clamp_en;
  logic               clamp_pol;
  logic               coast_pol;
  logic               midscale_sel;
  logic               ext_clk_sel;
  logic [PHASE_W-1:0] phase_reg;
  logic [7:0]         clamp_dly;
  logic [7:0]         clamp_dur;

  // Synchronised pins
  logic [5:0] pins_s;
  logic       hs_s;
  logic       clamp_s;
  logic       coast_s;
  logic       ext_s;
  logic       inv_s;
  logic       sog_s;
  logic       hs_prev;
  logic [2:0] edge_arm;

  // Derived
  logic       lead_edge;
  logic       trail_edge;
  logic       coast_act;
  logic       ext_clamp_act;
  logic       gen_active;
  logic       int_clk;
  logic [3:0] div_cnt;
  logic       next_pix;

  // All six asynchronous pins pass two flops before use; the register port is used directly
  scc_sync #(
    .W (6)
  ) u_sync (
    .clk      (sys_clk),
    .srst     (srst),
    .async_in ({hsync_in, clamp_in, coast_in, alt_pixel_clock_in,
                sample_clock_invert, green_embedded_sync_in}),
    .sync_out (pins_s)
  );

  assign {hs_s, clamp_s, coast_s, ext_s, inv_s, sog_s} = pins_s;

  // Register writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hsync_pol    <= HSYNC_POL_RST;
      ext_clamp_en <= EXT_CLAMP_RST;
      clamp_pol    <= CLAMP_POL_RST;
      coast_pol    <= COAST_POL_RST;
      midscale_sel <= MIDSCALE_RST;
      ext_clk_sel  <= EXT_CLK_SEL_RST;
      phase_reg    <= PHASE_RST;
      clamp_dly    <= CLAMP_DLY_RST;
      clamp_dur    <= CLAMP_DUR_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_PHASE:     phase_reg <= reg_wr_data[PHASE_W-1:0];
        REG_CLAMP_DLY: clamp_dly <= reg_wr_data;
        REG_CLAMP_DUR: clamp_dur <= reg_wr_data;
        REG_HSYNC_CTL: hsync_pol <= reg_wr_data[HSYNC_POL_BIT];
        REG_MODE_CTL: begin
          ext_clamp_en <= reg_wr_data[EXT_CLAMP_BIT];
          clamp_pol    <= reg_wr_data[CLAMP_POL_BIT];
          coast_pol    <= reg_wr_data[COAST_POL_BIT];
          midscale_sel <= reg_wr_data[MIDSCALE_BIT];
        end
        REG_CLOCK_CTL: ext_clk_sel <= reg_wr_data[EXT_CLK_SEL_BIT];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_PHASE:     reg_rd_data <= {{(8-PHASE_W){1'b0}}, phase_reg};
        REG_CLAMP_DLY: reg_rd_data <= clamp_dly;
        REG_CLAMP_DUR: reg_rd_data <= clamp_dur;
        REG_HSYNC_CTL: reg_rd_data <= 8'({hsync_pol, 6'h00});
        REG_MODE_CTL:  reg_rd_data <= {ext_clamp_en, clamp_pol, 2'h0, coast_pol, midscale_sel, 2'h0};
        REG_CLOCK_CTL: reg_rd_data <= {7'h00, ext_clk_sel};
        REG_STATUS:    reg_rd_data <= {2'h0, inv_s, ext_clk_sel, composite_sync_out,
                                       hs_s, pll_coast, clamp_active};
        default:       reg_rd_data <= 8'h00;
      endcase
    end else begin
      reg_rd_data <= 8'h00;
    end
  end

  // Previous hsync level for edge detection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hs_prev <= 1'b0;
    end else begin
      hs_prev <= hs_s;
    end
  end

  // Edge detection waits until the synchroniser and hs_prev both hold real pin levels.
  // Otherwise an idle-high pin climbing from the reset zero would look like an edge.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      edge_arm <= 3'h0;
    end else begin
      edge_arm <= {edge_arm[1:0], 1'b1};
    end
  end

  // Leading edge: falling when polarity 0, rising when 1; trailing is the other
  assign lead_edge     = edge_arm[2] && (hs_prev != hs_s) && (hs_s == hsync_pol);
  assign trail_edge    = edge_arm[2] && (hs_prev != hs_s) && (hs_s != hsync_pol);
  assign coast_act     = (coast_s == coast_pol);
  assign ext_clamp_act = (clamp_s == clamp_pol);

  scc_clamp_gen u_clamp_gen (
    .clk      (sys_clk),
    .srst     (srst),
    .start    (trail_edge),
    .delay    (clamp_dly),
    .duration (clamp_dur),
    .active   (gen_active)
  );

  // Clamp source select; the pin is ignored unless enabled
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clamp_active      <= 1'b0;
      clamp_to_midscale <= MIDSCALE_RST;
    end else begin
      clamp_active      <= ext_clamp_en ? ext_clamp_act : gen_active;
      clamp_to_midscale <= midscale_sel;
    end
  end

  // Reference edge to the clock generator, held back while coasting
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pll_ref_edge <= 1'b0;
      pll_coast    <= 1'b0;
    end else begin
      pll_ref_edge <= lead_edge && !coast_act;
      pll_coast    <= coast_act;
    end
  end

  // Internal pixel clock: realigned on each leading edge, free running in coast
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_cnt <= 4'h0;
      int_clk <= 1'b0;
    end else if (lead_edge && !coast_act) begin
      div_cnt <= 4'h0;
      int_clk <= 1'b1;
    end else if (div_cnt == PIX_HALF_CYCLES - 4'h1) begin
      div_cnt <= 4'h0;
      int_clk <= !int_clk;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // External clock replaces the internal one; nothing else changes
  assign next_pix = ext_clk_sel ? ext_s : int_clk;

  // Sampling clock; inversion is a half period shift, toggled per frame for alternate pixels
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pixel_clock_out       <= 1'b0;
      sample_clock_out      <= 1'b0;
      sample_clock_inverted <= 1'b0;
      pixel_clock_ext_sel   <= EXT_CLK_SEL_RST;
    end else begin
      pixel_clock_out       <= next_pix;
      sample_clock_out      <= next_pix ^ inv_s;
      sample_clock_inverted <= inv_s;
      pixel_clock_ext_sel   <= ext_clk_sel;
    end
  end

  // Phase adjust passes through in both clock modes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase_adjust <= PHASE_RST;
    end else begin
      phase_adjust <= phase_reg;
    end
  end

  // Composite sync: comparator result, same sense
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      composite_sync_out <= 1'b0;
    end else begin
      composite_sync_out <= sog_s;
    end
  end

  property p_ext_clamp;
    @(posedge sys_clk) disable iff (srst)
      ext_clamp_en |=> clamp_active == ($past(clamp_s) == $past(clamp_pol));
  endproperty
  a_ext_clamp: assert property (p_ext_clamp) else $error("external clamp not followed");

  property p_int_clamp;
    @(posedge sys_clk) disable iff (srst)
      !ext_clamp_en |=> clamp_active == $past(gen_active);
  endproperty
  a_int_clamp: assert property (p_int_clamp) else $error("clamp pin not ignored");

  property p_midscale;
    @(posedge sys_clk) disable iff (srst)
      1'b1 |=> clamp_to_midscale == $past(midscale_sel);
  endproperty
  a_midscale: assert property (p_midscale) else $error("clamp level wrong");

  property p_coast_blocks;
    @(posedge sys_clk) disable iff (srst)
      pll_coast |-> !pll_ref_edge;
  endproperty
  a_coast_blocks: assert property (p_coast_blocks) else $error("reference edge during coast");

  property p_coast_sense;
    @(posedge sys_clk) disable iff (srst)
      1'b1 |=> pll_coast == ($past(coast_s) == $past(coast_pol));
  endproperty
  a_coast_sense: assert property (p_coast_sense) else $error("coast sense wrong");

  property p_ext_clock;
    @(posedge sys_clk) disable iff (srst)
      ext_clk_sel |=> pixel_clock_out == $past(ext_s) && pixel_clock_ext_sel;
  endproperty
  a_ext_clock: assert property (p_ext_clock) else $error("external clock not used");

  property p_phase;
    @(posedge sys_clk) disable iff (srst)
      ext_clk_sel |=> phase_adjust == $past(phase_reg);
  endproperty
  a_phase: assert property (p_phase) else $error("phase adjust stalled");

  property p_invert;
    @(posedge sys_clk) disable iff (srst)
      sample_clock_out == (pixel_clock_out ^ sample_clock_inverted);
  endproperty
  a_invert: assert property (p_invert) else $error("sample clock inversion wrong");

  property p_csync;
    @(posedge sys_clk) disable iff (srst)
      1'b1 |=> composite_sync_out == $past(sog_s);
  endproperty
  a_csync: assert property (p_csync) else $error("composite sync inverted or late");

  property p_lead_edge;
    @(posedge sys_clk) disable iff (srst)
      pll_ref_edge |-> $past(hs_s) != $past(hs_prev) && $past(hs_s) == $past(hsync_pol);
  endproperty
  a_lead_edge: assert property (p_lead_edge) else $error("wrong hsync edge used");

endmodule : scc_top

// ---- tb/scc_partner.sv ----
// Graphics source model: hsync, green sync, spare clock, inversion pin
`timescale 1ns/100ps
module scc_partner (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic inv_req,
  output logic      hsync_in,
  output logic      green_embedded_sync_in,
  output logic      alt_pixel_clock_in,
  output logic      sample_clock_invert
);
  logic [5:0] line_cnt;
  logic [1:0] ck_cnt;

  // Known pin levels before the first edge
  initial begin
    line_cnt = 6'h00;
    ck_cnt = 2'h0;
    hsync_in = 1'b1;
    green_embedded_sync_in = 1'b1;
    alt_pixel_clock_in = 1'b0;
    sample_clock_invert = 1'b0;
  end

  // Line of 64 cycles, active low sync; green sync longer to tell them apart
  always @(posedge sys_clk) begin
    line_cnt <= srst ? 6'h00 : line_cnt + 6'h01;
    hsync_in <= ~(line_cnt < 6'h08);
    green_embedded_sync_in <= ~(line_cnt < 6'h0C);
  end

  // Free running far side oscillator, period 6 cycles
  always @(posedge sys_clk) begin
    ck_cnt <= (ck_cnt == 2'h2) ? 2'h0 : ck_cnt + 2'h1;
    if (ck_cnt == 2'h2) alt_pixel_clock_in <= ~alt_pixel_clock_in;
  end

  // Inversion moves only inside sync blanking, never mid line
  always @(posedge sys_clk) begin
    if (srst) sample_clock_invert <= 1'b0;
    else if (line_cnt == 6'h02) sample_clock_invert <= inv_req;
  end
endmodule : scc_partner

// ---- tb/sync_clamp_clock_control_tb_top.sv ----
// Self-checking bench of the sync, clamp and pixel clock control
`timescale 1ns/100ps
module sync_clamp_clock_control_tb_top;
  import scc_pkg::*;
  logic sys_clk, srst, reg_wr, reg_rd, clamp_in, coast_in, inv_req, pq;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, rd_val, d, u;
  logic hsync_in, green_embedded_sync_in, alt_pixel_clock_in, sample_clock_invert;
  logic clamp_active, clamp_to_midscale, pll_ref_edge, pll_coast, pixel_clock_ext_sel;
  logic pixel_clock_out, sample_clock_out, sample_clock_inverted, composite_sync_out;
  logic [PHASE_W-1:0] phase_adjust;
  logic [3:0] hs_h, gs_h, iv_h;
  logic chk_edge, edge_pol;
  logic [31:0] seed;
  int bad_count, n_compared, cyc, since_rst, k, n;

  scc_top i_dut (.sys_clk, .srst, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data,
    .hsync_in, .clamp_in, .coast_in, .alt_pixel_clock_in, .sample_clock_invert,
    .green_embedded_sync_in, .clamp_active, .clamp_to_midscale, .pll_ref_edge, .pll_coast,
    .pixel_clock_ext_sel, .pixel_clock_out, .sample_clock_out, .sample_clock_inverted,
    .phase_adjust, .composite_sync_out);
  scc_partner i_far (.sys_clk, .srst, .inv_req, .hsync_in, .green_embedded_sync_in,
    .alt_pixel_clock_in, .sample_clock_invert);

  // 125 MHz
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Pin at its active level, bit one meaning active high
  function automatic logic hit(input logic l, input logic p);
    return l == p;
  endfunction : hit

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (e !== g) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : check

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wr_data <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rd_val = reg_rd_data;
  endtask : rd

  task automatic nwait(input int c);
    repeat (c) @(negedge sys_clk);
  endtask : nwait

  // Pin history; synced outputs trail the pins by three edges
  always @(posedge sys_clk) begin
    hs_h <= {hs_h[2:0], hsync_in};
    gs_h <= {gs_h[2:0], green_embedded_sync_in};
    iv_h <= {iv_h[2:0], sample_clock_invert};
    since_rst <= srst ? 0 : since_rst + 1;
    cyc <= cyc + 1;
    if (cyc > 10000) begin
      bad_count++;
      results();
    end
  end

  // Every-cycle checks once the synchronisers have flushed
  always @(negedge sys_clk) begin
    if (since_rst > 5) begin
      check("csync", gs_h[2], composite_sync_out);
      check("inv", iv_h[2], sample_clock_inverted);
      check("sclk", pixel_clock_out ^ sample_clock_inverted, sample_clock_out);
      if (chk_edge) check("ref", hs_h[2] == edge_pol && hs_h[3] != edge_pol, pll_ref_edge);
    end
  end

  initial begin
    srst = 1'b1;
    {reg_wr, reg_rd, clamp_in, coast_in, inv_req, chk_edge, edge_pol} = 7'h00;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    {bad_count, n_compared, cyc, since_rst} = 0;
    seed = 32'hFE8E;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    // Reset values, then the unmapped hole
    rd(REG_MODE_CTL);
    check("mode", {EXT_CLAMP_RST, CLAMP_POL_RST, 2'h0, COAST_POL_RST, MIDSCALE_RST, 2'h0}, rd_val & 8'hCC);
    rd(REG_CLOCK_CTL);
    check("clkctl", {7'h00, EXT_CLK_SEL_RST}, rd_val & 8'h01);
    rd(REG_CLAMP_DLY);
    check("dly", CLAMP_DLY_RST, rd_val);
    wr(8'h33, 8'h5A);
    rd(8'h33);
    check("hole", 8'h00, rd_val);
    $display("done reset");
    // Leading edge follows the polarity bit
    for (int p = 0; p < 2; p++) begin
      wr(REG_HSYNC_CTL, 8'(p) << HSYNC_POL_BIT);
      edge_pol = p[0];
      nwait(6);
      chk_edge = 1'b1;
      n = 0;
      repeat (128) begin
        @(negedge sys_clk);
        n += pll_ref_edge;
      end
      chk_edge = 1'b0;
      check("ref_n", 8'h02, 8'(n));
    end
    wr(REG_HSYNC_CTL, 8'h00);
    $display("done edge");
    // Internal clamp timing; clamp pin held active must be ignored
    @(posedge sys_clk) clamp_in <= 1'b1;
    repeat (3) begin
      seed = lfsr(seed);
      d = 8'(seed[4:0]) + 8'h01;
      u = 8'(seed[11:8]) + 8'h01;
      wr(REG_CLAMP_DLY, d);
      wr(REG_CLAMP_DUR, u);
      wr(REG_MODE_CTL, 8'h48 | (8'(seed[12]) << MIDSCALE_BIT));
      nwait(64);
      check("mid", seed[12], clamp_to_midscale);
      for (k = 0; k < 80 && pll_ref_edge !== 1'b1; k++) @(negedge sys_clk);
      for (k = 0; k < 80 && clamp_active !== 1'b1; k++) @(negedge sys_clk);
      check("clamp_dly", d + 8'h0A, 8'(k));
      for (n = 0; n < 80 && clamp_active === 1'b1; n++) @(negedge sys_clk);
      check("clamp_dur", u, 8'(n));
    end
    $display("done int clamp");
    // External clamp with both polarities and both levels
    for (int m = 0; m < 4; m++) begin
      wr(REG_MODE_CTL, 8'h88 | (8'(m[1]) << CLAMP_POL_BIT));
      @(posedge sys_clk) clamp_in <= m[0];
      nwait(4);
      check("ext_clamp", hit(m[0], m[1]), clamp_active);
    end
    wr(REG_MODE_CTL, 8'h48);
    $display("done ext clamp");
    // Coast: sense from polarity, hsync dropped, clock keeps running
    for (int m = 0; m < 4; m++) begin
      wr(REG_MODE_CTL, 8'h40 | (8'(m[1]) << COAST_POL_BIT));
      @(posedge sys_clk) coast_in <= m[0];
      nwait(4);
      check("coast", hit(m[0], m[1]), pll_coast);
      {n, k} = 0;
      pq = pixel_clock_out;
      repeat (128) begin
        @(negedge sys_clk);
        n += pll_ref_edge;
        k += pixel_clock_out && !pq;
        pq = pixel_clock_out;
      end
      check("coast_ref", hit(m[0], m[1]) ? 8'h00 : 8'h02, 8'(n));
      if (hit(m[0], m[1])) check("coast_clk", 8'h10, 8'(k));
    end
    @(posedge sys_clk) coast_in <= 1'b0;
    wr(REG_MODE_CTL, 8'h48);
    $display("done coast");
    // Outside clock replaces the divider, phase still adjustable
    wr(REG_CLOCK_CTL, 8'h01);
    nwait(4);
    check("ext_sel", 8'h01, pixel_clock_ext_sel);
    k = 0;
    pq = pixel_clock_out;
    repeat (120) begin
      @(negedge sys_clk);
      k += pixel_clock_out != pq;
      pq = pixel_clock_out;
    end
    check("ext_tog", 8'h01, k >= 39 && k <= 41);
    seed = lfsr(seed);
    wr(REG_PHASE, 8'(seed[4:0]));
    nwait(2);
    check("phase", seed[4:0], phase_adjust);
    $display("done ext clock");
    // Alternate frames: odd pixels, then even after inversion flips
    for (int f = 0; f < 2; f++) begin
      @(posedge sys_clk) inv_req <= !f[0];
      nwait(70);
      check("alt", !f[0], sample_clock_inverted);
    end
    $display("done invert");
    results();
  end
endmodule : sync_clamp_clock_control_tb_top
